/* hw/dsc_pkg.sv */
/*
 package of the serial debug command link: opcodes, response words,
 decode function, host register map and link timing.
 assumes both ends run on one 10 MHz processor clock.
*/
package dsc_pkg;
    localparam int          PKT_W         = 17;
    localparam logic [4:0]  LAST_BIT      = 5'h10;
    localparam logic [11:0] OP_CPU_RD     = 12'h218;
    localparam logic [11:0] OP_CPU_WR     = 12'h208;
    localparam logic [7:0]  OP_MEM_RD     = 8'h19;
    localparam logic [7:0]  OP_MEM_WR     = 8'h18;
    localparam logic [7:0]  OP_DUMP       = 8'h1d;
    localparam logic [7:0]  OP_FILL       = 8'h1c;
    localparam logic [7:0]  OP_DBG_RD     = 8'h2d;
    localparam logic [7:0]  OP_DBG_WR     = 8'h2c;
    localparam logic [2:0]  DBG_PAT       = 3'h4;
    localparam logic [15:0] OP_GO         = 16'h0c00;
    localparam logic [15:0] OP_NOP        = 16'h0000;
    localparam logic [15:0] OP_CTL_RD     = 16'h2980;
    localparam logic [15:0] OP_CTL_WR     = 16'h2880;
    localparam logic [16:0] RSP_NOT_READY = 17'h10000;
    localparam logic [16:0] RSP_BUS_ERR   = 17'h10001;
    localparam logic [16:0] RSP_ILLEGAL   = 17'h1ffff;
    localparam logic [16:0] RSP_OK        = 17'h0ffff;
    localparam logic [1:0]  SZ_BYTE       = 2'h0;
    localparam logic [1:0]  SZ_WORD       = 2'h1;
    localparam logic [1:0]  SZ_LONG       = 2'h2;
    localparam logic [1:0]  SZ_RSVD       = 2'h3;
    // host register map, one aligned word each
    localparam logic [31:0] ADDR_TX       = 32'h0000_0000;
    localparam logic [31:0] ADDR_RX       = 32'h0000_0004;
    localparam logic [31:0] ADDR_STAT     = 32'h0000_0008;
    localparam logic [1:0]  AXI_OKAY      = 2'h0;
    localparam logic [1:0]  AXI_SLVERR    = 2'h2;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    // link timing
    localparam int MCLK_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam int SCLK_HALF      = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);

    typedef enum logic [3:0] {K_NOP, K_CPU_RD, K_CPU_WR, K_MEM_RD,
        K_MEM_WR, K_DUMP, K_FILL, K_GO, K_CTL_RD, K_CTL_WR, K_DBG_RD,
        K_DBG_WR, K_ILLEGAL} dsc_kind_t;
    typedef enum logic [1:0] {C_HALTED, C_STEAL, C_PARALLEL} dsc_class_t;
    typedef enum logic [1:0] {ST_OPC, ST_EXT, ST_EXEC} dsc_dev_state_t;

    typedef struct packed {
        dsc_kind_t  kind;
        dsc_class_t cls;
        logic [1:0] size;
        logic [2:0] n_ext;
        logic [1:0] n_res;
        logic       has_addr;
        logic       rd;
    } dsc_dec_t;

    // classify an opcode word
    function automatic dsc_dec_t dsc_decode(input logic [15:0] op);
        dsc_dec_t d;
        logic     lg;
        d = '{kind: K_ILLEGAL, cls: C_PARALLEL, size: SZ_LONG,
              n_ext: 3'h0, n_res: 2'h1, has_addr: 1'b0, rd: 1'b0};
        lg = (op[7:6] == SZ_LONG);
        if (op[15:4] == OP_CPU_RD)
        begin
            d.kind = K_CPU_RD; d.cls = C_HALTED; d.n_res = 2'h2;
            d.rd = 1'b1;
        end
        else if (op[15:4] == OP_CPU_WR)
        begin
            d.kind = K_CPU_WR; d.cls = C_HALTED; d.n_ext = 3'h2;
        end
        else if (op[7:6] != SZ_RSVD && op[5:0] == 6'h00 &&
                 (op[15:8] == OP_MEM_RD || op[15:8] == OP_MEM_WR ||
                  op[15:8] == OP_DUMP || op[15:8] == OP_FILL))
        begin
            d.cls  = C_STEAL;
            d.size = op[7:6];
            d.rd   = (op[15:8] == OP_MEM_RD || op[15:8] == OP_DUMP);
            d.n_res = (d.rd && lg) ? 2'h2 : 2'h1;
            case (op[15:8])
                OP_MEM_RD: begin d.kind = K_MEM_RD; d.n_ext = 3'h2;
                    d.has_addr = 1'b1; end
                OP_MEM_WR: begin d.kind = K_MEM_WR; d.has_addr = 1'b1;
                    d.n_ext = lg ? 3'h4 : 3'h3; end
                OP_DUMP:   d.kind = K_DUMP;
                default: begin d.kind = K_FILL;
                    d.n_ext = lg ? 3'h2 : 3'h1; end
            endcase
        end
        else if (op == OP_GO)
        begin
            d.kind = K_GO; d.cls = C_HALTED;
        end
        else if (op == OP_NOP)
            d.kind = K_NOP;
        else if (op == OP_CTL_RD)
        begin
            d.kind = K_CTL_RD; d.cls = C_HALTED; d.n_ext = 3'h2;
            d.has_addr = 1'b1; d.n_res = 2'h2; d.rd = 1'b1;
        end
        else if (op == OP_CTL_WR)
        begin
            d.kind = K_CTL_WR; d.cls = C_HALTED; d.n_ext = 3'h4;
            d.has_addr = 1'b1;
        end
        else if (op[15:8] == OP_DBG_RD && op[7:5] == DBG_PAT)
        begin
            d.kind = K_DBG_RD; d.n_res = 2'h2; d.rd = 1'b1;
        end
        else if (op[15:8] == OP_DBG_WR && op[7:5] == DBG_PAT)
        begin
            d.kind = K_DBG_WR; d.n_ext = 3'h2;
        end
        return d;
    endfunction

    // byte step of one operand
    function automatic logic [31:0] dsc_step(input logic [1:0] sz);
        return (sz == SZ_LONG) ? 32'h4 : (sz == SZ_WORD) ? 32'h2 : 32'h1;
    endfunction

    // forced alignment of memory addresses
    function automatic logic [31:0] dsc_align(input logic [31:0] a,
                                              input logic [1:0]  sz);
        return a & ~(dsc_step(sz) - 32'h1);
    endfunction
endpackage

/* hw/dsc_link_if.sv */
/*
 three-wire serial debug link between host and device.
 assumes both ends clock their logic from the same processor clock.
*/
`timescale 1ns/1ps
interface dsc_link_if;
    logic serial_debug_clock;
    logic serial_debug_in;
    logic serial_debug_out;
    modport device (input serial_debug_clock, input serial_debug_in,
                    output serial_debug_out);
    modport host (output serial_debug_clock, output serial_debug_in,
                  input serial_debug_out);
endinterface

/* hw/dsc_device.sv */
/*
 device end of the serial debug link: shifts 17-bit packets, decodes
 commands, gathers extension words, issues them to core logic and
 queues the response words.
 assumes core logic answers each issued command with one done pulse.
*/
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dsc_device
    import dsc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // serial link
    dsc_link_if.device       link,
    // core status
    input  wire logic        halted,
    // issued command
    output logic             cmd_valid,
    output dsc_kind_t        cmd_kind,
    output dsc_class_t       cmd_class,
    output logic [1:0]       cmd_size,
    output logic [4:0]       cmd_reg,
    output logic [31:0]      cmd_addr,
    output logic [31:0]      cmd_data,
    // completion from core
    input  wire logic        done,
    input  wire logic        done_err,
    input  wire logic [31:0] done_rdata
);
    typedef struct packed {
        dsc_dev_state_t st;
        logic           sclk_s1;
        logic           sclk_s2;
        logic           sclk_d;
        logic           sdi_s1;
        logic           sdi_s2;
        logic           sdo;
        logic [4:0]     bitcnt;
        logic [15:0]    rx;
        logic [15:0]    tx;
        logic [16:0]    resp0;
        logic [16:0]    resp1;
        logic [1:0]     resp_n;
        dsc_dec_t       dec;
        logic [2:0]     ext_idx;
        dsc_kind_t      prev_kind;
        logic           cmd_valid;
        logic [4:0]     cmd_reg;
        logic [31:0]    cmd_addr;
        logic [31:0]    cmd_data;
    } dsc_dev_t;

    dsc_dev_t    q;
    dsc_dev_t    next_q;
    logic        rise;
    logic [16:0] word;
    logic [15:0] w;
    dsc_dec_t    dw;
    logic        bad;

    // outputs straight from state
    assign link.serial_debug_out = q.sdo;
    assign cmd_valid = q.cmd_valid;
    assign cmd_kind  = q.dec.kind;
    assign cmd_class = q.dec.cls;
    assign cmd_size  = q.dec.size;
    assign cmd_reg   = q.cmd_reg;
    assign cmd_addr  = q.cmd_addr;
    assign cmd_data  = q.cmd_data;

    // next-state logic
    always_comb
    begin
        next_q = q;
        // pins pass two flops; edge is taken from the second and third
        next_q.sclk_s1 = link.serial_debug_clock;
        next_q.sclk_s2 = q.sclk_s1;
        next_q.sclk_d  = q.sclk_s2;
        next_q.sdi_s1  = link.serial_debug_in;
        next_q.sdi_s2  = q.sdi_s1;
        next_q.cmd_valid = 1'b0;
        rise = q.sclk_s2 & ~q.sclk_d;
        w    = {q.rx[14:0], q.sdi_s2};
        dw   = dsc_decode(w);
        word = RSP_OK;
        bad  = (dw.kind == K_ILLEGAL) ||
               (dw.cls == C_HALTED && !halted) ||
               (dw.kind == K_DUMP && q.prev_kind != K_MEM_RD &&
                q.prev_kind != K_DUMP) ||
               (dw.kind == K_FILL && q.prev_kind != K_MEM_WR &&
                q.prev_kind != K_FILL);
        if (rise)
        begin
            if (q.bitcnt == 5'h00)
            begin
                // response picked as the packet starts
                if (q.resp_n != 2'h0)
                begin
                    word = q.resp0;
                    next_q.resp0  = q.resp1;
                    next_q.resp_n = q.resp_n - 2'h1;
                end
                else if (q.st != ST_OPC)
                    word = RSP_NOT_READY;
                else
                    word = RSP_OK;
                next_q.sdo = word[16];
                next_q.tx  = word[15:0];
            end
            else
            begin
                next_q.sdo = q.tx[15];
                next_q.tx  = {q.tx[14:0], 1'b0};
            end
            next_q.rx = w;
            if (q.bitcnt == LAST_BIT)
            begin
                next_q.bitcnt = 5'h00;
                case (q.st)
                    ST_OPC:
                    begin
                        if (bad)
                        begin
                            next_q.resp0     = RSP_ILLEGAL;
                            next_q.resp_n    = 2'h1;
                            next_q.prev_kind = K_ILLEGAL;
                        end
                        else
                        begin
                            next_q.dec       = dw;
                            next_q.prev_kind = dw.kind;
                            next_q.ext_idx   = 3'h0;
                            next_q.cmd_data  = RST_WORD;
                            next_q.cmd_reg   = (dw.kind == K_CPU_RD ||
                                dw.kind == K_CPU_WR) ?
                                {1'b0, w[3:0]} : w[4:0];
                            // block ops walk on from the last address
                            if (dw.kind == K_DUMP || dw.kind == K_FILL)
                                next_q.cmd_addr = dsc_align(q.cmd_addr +
                                    dsc_step(dw.size), dw.size);
                            // null command keeps queued results and the
                            // block chain; idle answer is ok anyway
                            if (dw.kind == K_NOP)
                                next_q.prev_kind = q.prev_kind;
                            else if (dw.n_ext == 3'h0)
                            begin
                                next_q.st        = ST_EXEC;
                                next_q.cmd_valid = 1'b1;
                            end
                            else
                                next_q.st = ST_EXT;
                        end
                    end
                    ST_EXT:
                    begin
                        // address words first, then operand words
                        if (q.dec.has_addr && q.ext_idx < 3'h2)
                            next_q.cmd_addr = {q.cmd_addr[15:0], w};
                        else
                            next_q.cmd_data = {q.cmd_data[15:0], w};
                        next_q.ext_idx = q.ext_idx + 3'h1;
                        if (q.ext_idx + 3'h1 == q.dec.n_ext)
                        begin
                            next_q.st        = ST_EXEC;
                            next_q.cmd_valid = 1'b1;
                            if (q.dec.kind == K_MEM_RD ||
                                q.dec.kind == K_MEM_WR)
                                next_q.cmd_addr = dsc_align(
                                    next_q.cmd_addr, q.dec.size);
                        end
                    end
                    ST_EXEC:
                        // words during an access are dropped
                        next_q.st = ST_EXEC;
                    default:
                        next_q.st = ST_OPC;
                endcase
            end
            else
                next_q.bitcnt = q.bitcnt + 5'h01;
        end
        // completion from core fills the response queue
        if (q.st == ST_EXEC && done)
        begin
            next_q.st     = ST_OPC;
            next_q.resp_n = 2'h1;
            if (done_err)
                next_q.resp0 = RSP_BUS_ERR;
            else if (q.dec.n_res == 2'h2)
            begin
                next_q.resp0  = {1'b0, done_rdata[31:16]};
                next_q.resp1  = {1'b0, done_rdata[15:0]};
                next_q.resp_n = 2'h2;
            end
            else if (q.dec.rd)
                next_q.resp0 = {1'b0, done_rdata[15:0]};
            else
                next_q.resp0 = RSP_OK;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            q           <= '0;
            q.st        <= ST_OPC;
            q.prev_kind <= K_ILLEGAL;
            q.dec.kind  <= K_NOP;
        end
        else
            q <= next_q;
    end
endmodule // dsc_device

/* hw/dsc_host.sv */
/*
 host end of the serial debug link: AXI4-Lite slave with transmit,
 receive and status words; generates the serial clock by division.
 assumes software writes a packet only while the link is idle.
*/
`timescale 1ns/1ps
module dsc_host
    import dsc_pkg::*;
#(
    parameter int HALF = SCLK_HALF
)
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // axi4-lite slave
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // serial link
    dsc_link_if.host         link
);
    localparam logic [7:0] H_LO  = 8'(HALF - 1);
    localparam logic [7:0] H_HI  = 8'(HALF);
    localparam logic [7:0] H_END = 8'(2 * HALF - 1);

    typedef struct packed {
        logic        awready, wready, bvalid, arready, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        aw_held, w_held;
        logic [31:0] aw_addr, w_data;
        logic [3:0]  w_strb;
        logic        sclk, sdi, sdo_s1, sdo_s2, busy;
        logic [7:0]  cnt;
        logic [4:0]  bitn;
        logic [15:0] tx_word;
        logic [16:0] txsh, rxsh, rx_last;
    } dsc_host_t;

    dsc_host_t q;
    dsc_host_t next_q;

    assign awready = q.awready;
    assign wready  = q.wready;
    assign bresp   = q.bresp;
    assign bvalid  = q.bvalid;
    assign arready = q.arready;
    assign rdata   = q.rdata;
    assign rresp   = q.rresp;
    assign rvalid  = q.rvalid;
    assign link.serial_debug_clock = q.sclk;
    assign link.serial_debug_in    = q.sdi;

    always_comb
    begin
        next_q = q;
        next_q.sdo_s1 = link.serial_debug_out;
        next_q.sdo_s2 = q.sdo_s1;
        // write channels taken in either order
        if (awvalid && q.awready)
        begin
            next_q.aw_held = 1'b1;
            next_q.aw_addr = awaddr;
        end
        if (wvalid && q.wready)
        begin
            next_q.w_held = 1'b1;
            next_q.w_data = wdata;
            next_q.w_strb = wstrb;
        end
        if (q.bvalid && bready)
            next_q.bvalid = 1'b0;
        if (q.aw_held && q.w_held && !q.bvalid)
        begin
            next_q.aw_held = 1'b0;
            next_q.w_held  = 1'b0;
            next_q.bvalid  = 1'b1;
            next_q.bresp   = AXI_OKAY;
            if (q.aw_addr == ADDR_TX)
            begin
                // a packet while busy is dropped, not queued
                if (!q.busy && q.w_strb[1:0] == 2'h3)
                begin
                    next_q.tx_word = q.w_data[15:0];
                    next_q.txsh = {1'b0, q.w_data[15:0]};
                    next_q.busy = 1'b1;
                    next_q.cnt  = 8'h00;
                    next_q.bitn = 5'h00;
                end
            end
            else if (q.aw_addr != ADDR_RX && q.aw_addr != ADDR_STAT)
                next_q.bresp = AXI_SLVERR;
        end
        next_q.awready = !next_q.aw_held && !next_q.bvalid;
        next_q.wready  = !next_q.w_held && !next_q.bvalid;
        // read channel
        if (q.rvalid && rready)
            next_q.rvalid = 1'b0;
        if (arvalid && q.arready)
        begin
            next_q.rvalid = 1'b1;
            next_q.rresp  = AXI_OKAY;
            case (araddr)
                ADDR_TX:   next_q.rdata = {16'h0000, q.tx_word};
                ADDR_RX:   next_q.rdata = {15'h0000, q.rx_last};
                ADDR_STAT: next_q.rdata = {31'h0000_0000, q.busy};
                default:
                begin
                    next_q.rdata = RST_WORD;
                    next_q.rresp = AXI_SLVERR;
                end
            endcase
        end
        next_q.arready = !next_q.rvalid;
        // bit engine: low half, high half, sample before next rise
        if (q.busy)
        begin
            next_q.cnt = (q.cnt == H_END) ? 8'h00 : q.cnt + 8'h01;
            if (q.cnt == 8'h00 && q.bitn < 5'(PKT_W))
            begin
                next_q.sdi  = q.txsh[16];
                next_q.txsh = {q.txsh[15:0], 1'b0};
            end
            if (q.cnt == H_LO && q.bitn != 5'h00)
            begin
                next_q.rxsh = {q.rxsh[15:0], q.sdo_s2};
                if (q.bitn == 5'(PKT_W))
                begin
                    next_q.busy    = 1'b0;
                    next_q.rx_last = {q.rxsh[15:0], q.sdo_s2};
                end
            end
            if (q.cnt == H_HI && q.bitn < 5'(PKT_W))
                next_q.sclk = 1'b1;
            if (q.cnt == H_END)
            begin
                next_q.sclk = 1'b0;
                next_q.bitn = q.bitn + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            q <= '0;
        else
            q <= next_q;
    end
endmodule // dsc_host

/* tb/dsc_link_properties.sv */
/*
 link and issue checks of the serial debug command link.
 assumes one mclk domain, synchronous active-high srst.
*/
`timescale 1ns/1ps
module dsc_link_properties
    import dsc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // link wires
    input  wire logic       serial_debug_clock,
    input  wire logic       serial_debug_in,
    input  wire logic       serial_debug_out,
    // device issue side
    input  wire logic       halted,
    input  wire logic       cmd_valid,
    input  dsc_kind_t       cmd_kind,
    input  dsc_class_t      cmd_class,
    input  wire logic [1:0] cmd_size
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // start of the high phase of one bit
    sequence s_rise;
        !serial_debug_clock ##1 serial_debug_clock;
    endsequence
    // data bit held while the device samples it
    sequence s_hold;
        $stable(serial_debug_in) [*2];
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) srst |=>
        !serial_debug_clock && !serial_debug_out && !cmd_valid)
        else $error("link not idle after reset");
    a_sdi_hold: assert property (s_rise |-> s_hold)
        else $error("host data moved during clock high");
    a_sdo_launch: assert property ($changed(serial_debug_out) |->
        $past(serial_debug_clock, 3))
        else $error("device output changed off the bit edge");
    a_issue_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("issue pulse longer than one cycle");
    a_halted_gate: assert property (cmd_valid &&
        cmd_class == C_HALTED |-> halted)
        else $error("halted command issued while running");
    a_steal_class: assert property (cmd_valid && cmd_kind inside
        {K_MEM_RD, K_MEM_WR, K_DUMP, K_FILL} |->
        cmd_class == C_STEAL && cmd_size != SZ_RSVD)
        else $error("memory command wrongly classed");
    a_par_class: assert property (cmd_valid &&
        cmd_kind inside {K_DBG_RD, K_DBG_WR} |-> cmd_class == C_PARALLEL)
        else $error("debug register command not parallel");
    a_no_silent: assert property (cmd_valid |->
        !(cmd_kind inside {K_NOP, K_ILLEGAL}))
        else $error("no-op or illegal command issued");
endmodule // dsc_link_properties

/* tb/tb_debug_serial_command_decode.sv */
/*
 bench of the serial debug link: host and device joined by the link.
 assumes a core that answers three cycles after each issue.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb_debug_serial_command_decode;
    import dsc_pkg::*;
    localparam logic [31:0] RDATA = 32'h8421_c3a5;
    localparam logic [16:0] NR    = RSP_NOT_READY;
    logic        mclk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, halted = 0, done = 0, sclk_q = 0;
    logic        done_err = 0, err_next = 0;
    logic        awready, wready, bvalid, arready, rvalid, cmd_valid;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, cmd_addr;
    logic [31:0] cmd_data, c_addr, c_data;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, cmd_size, pend = 0;
    logic [4:0]  cmd_reg, c_reg;
    logic [16:0] wire_sh = 0;
    dsc_kind_t   cmd_kind, c_kind;
    dsc_class_t  cmd_class;
    int          n_errors = 0, n_checks = 0, cycles = 0;
    dsc_link_if link ();
    dsc_host i_dsc_host (.mclk(mclk), .srst(srst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .link(link));
    dsc_device i_dsc_device (.mclk(mclk), .srst(srst), .link(link),
        .halted(halted), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_class(cmd_class), .cmd_size(cmd_size), .cmd_reg(cmd_reg),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .done(done),
        .done_err(done_err), .done_rdata(RDATA));
    dsc_link_properties i_dsc_link_properties (.mclk(mclk), .srst(srst),
        .serial_debug_clock(link.serial_debug_clock),
        .serial_debug_in(link.serial_debug_in),
        .serial_debug_out(link.serial_debug_out), .halted(halted),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_class(cmd_class), .cmd_size(cmd_size));
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    // core stand-in: no cpu debug writes of its own
    always @(posedge mclk)
    begin
        pend <= {pend[0], cmd_valid};
        done <= pend[1];
        done_err <= pend[1] & err_next;
        if (cmd_valid)
        begin
            c_kind <= cmd_kind;
            c_reg  <= cmd_reg;
            c_addr <= cmd_addr;
            c_data <= cmd_data;
        end
        sclk_q <= link.serial_debug_clock;
        if (link.serial_debug_clock && !sclk_q)
            wire_sh <= {wire_sh[15:0], link.serial_debug_in};
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            final_report();
        end
    end
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1;
        wvalid  <= 1;
        bready  <= 1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 0;
            if (wready)
                wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1;
        rready  <= 1;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    // one whole packet out, polled to the end, answer compared
    task automatic xfer(input logic [15:0] p, input logic [16:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(ADDR_TX, {16'h0, p});
        d = 1;
        while (d[0])
            axi_rd(ADDR_STAT, d, r);
        axi_rd(ADDR_RX, d, r);
        `CHK(d[16:0], exp)
        `CHK(wire_sh, {1'b0, p})
    endtask
    task automatic t_mem_read;
        xfer(16'h1980, RSP_OK);
        xfer(16'h0000, NR);
        xfer(16'h1002, NR);
        `CHK(c_addr, 32'h1000)
        `CHK(c_kind, K_MEM_RD)
        xfer(OP_NOP, {1'b0, RDATA[31:16]});
        xfer(16'h1d80, {1'b0, RDATA[15:0]});
        `CHK(c_kind, K_DUMP)
        `CHK(c_addr, 32'h1004)
        xfer(OP_NOP, {1'b0, RDATA[31:16]});
        xfer(OP_NOP, {1'b0, RDATA[15:0]});
        $display("test mem_read done");
    endtask
    task automatic t_illegal;
        logic [15:0] ops [5] = '{16'h19c0, 16'hffff, OP_GO, 16'h1d00,
                                 16'h2d25};
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(32'h10, d, r);
        `CHK(r, AXI_SLVERR)
        foreach (ops[i])
            xfer(ops[i], i ? RSP_ILLEGAL : RSP_OK);
        xfer(OP_NOP, RSP_ILLEGAL);
        $display("test illegal done");
    endtask
    task automatic t_halted;
        halted <= 1;
        xfer(16'h208b, RSP_OK);
        xfer(16'h5a5a, NR);
        xfer(16'hc3c3, NR);
        `CHK(c_kind, K_CPU_WR)
        `CHK(c_reg, 5'h0b)
        `CHK(c_data, 32'h5a5a_c3c3)
        xfer(OP_CTL_WR, RSP_OK);
        xfer(16'h0000, NR);
        xfer(16'h0c05, NR);
        xfer(16'h1234, NR);
        xfer(16'h5678, NR);
        `CHK(c_kind, K_CTL_WR)
        `CHK(c_data, 32'h1234_5678)
        xfer(16'h218f, RSP_OK);
        `CHK(c_reg, 5'h0f)
        xfer(OP_NOP, {1'b0, RDATA[31:16]});
        xfer(OP_GO, {1'b0, RDATA[15:0]});
        `CHK(c_kind, K_GO)
        xfer(OP_NOP, RSP_OK);
        halted <= 0;
        $display("test halted done");
    endtask
    task automatic t_dbg_err;
        xfer(16'h2d85, RSP_OK);
        `CHK(c_reg, 5'h05)
        xfer(16'h2c86, {1'b0, RDATA[31:16]});
        xfer(16'hbeef, {1'b0, RDATA[15:0]});
        xfer(16'h0001, NR);
        `CHK(c_kind, K_DBG_WR)
        `CHK(c_data, 32'hbeef_0001)
        err_next = 1;
        xfer(16'h1840, RSP_OK);
        xfer(16'h0000, NR);
        xfer(16'h2003, NR);
        xfer(16'h7777, NR);
        err_next = 0;
        `CHK(c_addr, 32'h2002)
        xfer(16'h1c40, RSP_BUS_ERR);
        xfer(16'h1111, NR);
        `CHK(c_kind, K_FILL)
        `CHK(c_addr, 32'h2004)
        xfer(OP_NOP, RSP_OK);
        $display("test dbg_err done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        srst <= 0;
        t_mem_read();
        t_illegal();
        t_halted();
        t_dbg_err();
        final_report();
    end
endmodule // tb_debug_serial_command_decode
